// File: swt_top.sv
// Overview of operation
// - In window mode a refresh is the key 0xA5 written to the clear port, accepted only in the open period.
// - A refresh written while the closed window runs raises a system reset at once.
// - Closed and open lengths are each selectable from 8 ms to 16 s.
// - In window mode the whole timeout span is the closed length plus the open length.
// - The closed length comes from the closed-phase length field of the configuration.
// - The open length comes from the open-window length field of the configuration.
// - After reset the early-warning interrupt stays disabled until software enables it.
// - Writing 1 to the enable-set input enables the early-warning interrupt.
// - Writing 1 to the enable-clear input disables the early-warning interrupt unless enable-set is written in the same cycle.
// - With the interrupt enabled in window mode it fires when the closed window ends and the open one begins.
// - With the permanent-run lock set the timer counts whatever enable says, and only power-on reset clears it.
// - While locked, configuration is read-only but early-warning control and window enable still act.
`timescale 1ns/1ps
`include "swt_defs.svh"

module swt_top #(
  parameter int unsigned TICK_CYCLES = `SWT_CLK_HZ / `SWT_US_PER_S * `SWT_TICK_US
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic windowed_operation_enable,
  input wire logic permanent_run_lock_set,
  input wire logic cfg_write,
  input wire swt_pkg::swt_cfg_t cfg_data,
  input wire logic early_warning_irq_enable_set,
  input wire logic early_warning_irq_enable_clear,
  input wire swt_pkg::swt_refresh_t refresh,
  output logic system_reset,
  output logic early_warning_irq,
  output logic early_warning_irq_enable,
  output logic permanent_run_lock,
  output logic window_mode,
  output swt_pkg::swt_cfg_t cfg,
  output swt_pkg::swt_phase_t phase
);
  logic [14:0] count;
  logic [14:0] next_count;
  swt_pkg::swt_phase_t next_phase;
  swt_pkg::swt_cfg_t next_cfg;
  logic next_system_reset;
  logic next_early_warning_irq;
  logic next_irq_enable;
  logic next_lock;
  logic next_window_mode;
  logic tick_clear;
  logic tick;
  logic running;
  logic [14:0] closed_len;
  logic [14:0] open_len;
  logic [14:0] cur_len;
  swt_pkg::swt_phase_t start_phase;

  function automatic logic [14:0] sel_to_ticks(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `SWT_MAX_SEL) ? `SWT_MAX_SEL : sel;
    sel_to_ticks = `SWT_MIN_TICKS << s;
  endfunction

  swt_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .clear(tick_clear),
    .tick(tick)
  );

  assign running = enable | permanent_run_lock;
  assign closed_len = sel_to_ticks(cfg.closed_sel);
  assign open_len = sel_to_ticks(cfg.open_sel);
  assign cur_len = (phase == swt_pkg::SWT_PH_CLOSED) ? closed_len : open_len;
  assign start_phase = window_mode ? swt_pkg::SWT_PH_CLOSED : swt_pkg::SWT_PH_OPEN;

  // control and configuration
  always_comb
  begin
    next_lock = permanent_run_lock;
    next_cfg = cfg;
    next_irq_enable = early_warning_irq_enable;
    next_window_mode = windowed_operation_enable;
    if (permanent_run_lock_set)
    begin
      next_lock = 1'b1;
    end
    if (cfg_write && !permanent_run_lock)
    begin
      next_cfg = cfg_data;
    end
    if (early_warning_irq_enable_clear)
    begin
      next_irq_enable = 1'b0;
    end
    if (early_warning_irq_enable_set)
    begin
      next_irq_enable = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      permanent_run_lock <= 1'b0;
      cfg <= `SWT_CFG_RESET;
      early_warning_irq_enable <= 1'b0;
      window_mode <= 1'b0;
    end
    else
    begin
      permanent_run_lock <= next_lock;
      cfg <= next_cfg;
      early_warning_irq_enable <= next_irq_enable;
      window_mode <= next_window_mode;
    end
  end

  // timing phases
  always_comb
  begin
    next_phase = phase;
    next_count = count;
    next_system_reset = 1'b0;
    next_early_warning_irq = 1'b0;
    tick_clear = 1'b0;
    if (!running)
    begin
      next_phase = swt_pkg::SWT_PH_IDLE;
      next_count = '0;
      tick_clear = 1'b1;
    end
    else if (phase == swt_pkg::SWT_PH_IDLE)
    begin
      next_phase = start_phase;
      next_count = '0;
      tick_clear = 1'b1;
    end
    else if (refresh.valid)
    begin
      if (refresh.data != `SWT_KEY || phase == swt_pkg::SWT_PH_CLOSED)
      begin
        next_system_reset = 1'b1;
      end
      next_phase = start_phase;
      next_count = '0;
      tick_clear = 1'b1;
    end
    else if (tick)
    begin
      if (count >= cur_len - 15'h0001)
      begin
        next_count = '0;
        if (phase == swt_pkg::SWT_PH_CLOSED)
        begin
          next_phase = swt_pkg::SWT_PH_OPEN;
          next_early_warning_irq = early_warning_irq_enable;
        end
        else
        begin
          next_system_reset = 1'b1;
          next_phase = start_phase;
          tick_clear = 1'b1;
        end
      end
      else
      begin
        next_count = count + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= swt_pkg::SWT_PH_IDLE;
      count <= '0;
      system_reset <= 1'b0;
      early_warning_irq <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      count <= next_count;
      system_reset <= next_system_reset;
      early_warning_irq <= next_early_warning_irq;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_bad_key;
    running && phase != swt_pkg::SWT_PH_IDLE && refresh.valid && refresh.data != `SWT_KEY |=> system_reset;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key without reset");

  property p_closed_refresh;
    running && phase == swt_pkg::SWT_PH_CLOSED && refresh.valid
      |=> system_reset && phase == $past(start_phase) && count == '0;
  endproperty
  a_closed_refresh: assert property (p_closed_refresh) else $error("closed refresh not reset");

  property p_len_range;
    closed_len >= `SWT_MIN_TICKS && closed_len <= (`SWT_MIN_TICKS << `SWT_MAX_SEL)
      && open_len >= `SWT_MIN_TICKS && open_len <= (`SWT_MIN_TICKS << `SWT_MAX_SEL);
  endproperty
  a_len_range: assert property (p_len_range) else $error("length out of range");

  property p_count_bound;
    count < cur_len;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count past phase length");

  property p_cfg_write;
    cfg_write && !permanent_run_lock |=> cfg == $past(cfg_data);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not written");

  property p_open_len;
    phase == swt_pkg::SWT_PH_OPEN && tick && !refresh.valid && running && count == open_len - 15'h0001
      |=> system_reset && !early_warning_irq;
  endproperty
  a_open_len: assert property (p_open_len) else $error("open expiry not reset");

  property p_irq_off;
    $rose(early_warning_irq_enable) |-> $past(early_warning_irq_enable_set);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("enable rose unasked");

  property p_set;
    early_warning_irq_enable_set |=> early_warning_irq_enable;
  endproperty
  a_set: assert property (p_set) else $error("enable set lost");

  property p_clear;
    early_warning_irq_enable_clear && !early_warning_irq_enable_set |=> !early_warning_irq_enable;
  endproperty
  a_clear: assert property (p_clear) else $error("enable clear lost");

  property p_warn;
    phase == swt_pkg::SWT_PH_CLOSED && next_phase == swt_pkg::SWT_PH_OPEN && !refresh.valid
      |=> early_warning_irq == $past(early_warning_irq_enable) ##1 !early_warning_irq;
  endproperty
  a_warn: assert property (p_warn) else $error("early warning wrong");

  property p_lock;
    permanent_run_lock |=> permanent_run_lock && phase != swt_pkg::SWT_PH_IDLE;
  endproperty
  a_lock: assert property (p_lock) else $error("lock lost or idle");

  property p_locked_cfg;
    permanent_run_lock |=> $stable(cfg) && window_mode == $past(windowed_operation_enable);
  endproperty
  a_locked_cfg: assert property (p_locked_cfg) else $error("locked config changed");

  property p_restart;
    running && phase == swt_pkg::SWT_PH_OPEN && refresh.valid && refresh.data == `SWT_KEY
      |=> !system_reset && count == '0 && phase == $past(start_phase);
  endproperty
  a_restart: assert property (p_restart) else $error("valid refresh not restart");
endmodule // swt_top

// File: swt_defs.svh
`ifndef SWT_DEFS_SVH
`define SWT_DEFS_SVH

// clock rate and timebase tick
`define SWT_CLK_HZ 40000000
`define SWT_TICK_US 1000
`define SWT_US_PER_S 1000000

// refresh key
`define SWT_KEY 8'ha5

// shortest period in ticks (8 ms), largest length select (16 s)
`define SWT_MIN_TICKS 15'h0008
`define SWT_MAX_SEL 4'hb

// configuration reset: both lengths at the longest setting
`define SWT_CFG_RESET 8'hbb

`endif

// File: swt_pkg.sv
package swt_pkg;

  typedef struct packed {
    logic [3:0] closed_sel;
    logic [3:0] open_sel;
  } swt_cfg_t;

  typedef enum logic [1:0] {
    SWT_PH_IDLE = 2'b00,
    SWT_PH_CLOSED = 2'b01,
    SWT_PH_OPEN = 2'b10
  } swt_phase_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } swt_refresh_t;

endpackage

// File: swt_tick_gen.sv
`timescale 1ns/1ps

module swt_tick_gen #(
  parameter int unsigned TICK_CYCLES = 40000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);
  localparam int W = $clog2(TICK_CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_tick;

  // timebase divider
  always_comb
  begin
    next_count = count + W'(1);
    next_tick = 1'b0;
    if (clear)
    begin
      next_count = '0;
    end
    else if (count == LAST)
    begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule // swt_tick_gen

// File: swt_top_bench.sv
`timescale 1ns/1ps

module swt_top_bench;
  localparam int unsigned TICK = 4;
  logic clk;
  logic rst;
  logic enable;
  logic wen;
  logic lock_set;
  logic cfg_write;
  logic ew_set;
  logic ew_clr;
  swt_pkg::swt_cfg_t cfg_data;
  swt_pkg::swt_refresh_t refresh;
  logic system_reset;
  logic early_warning_irq;
  logic ew_en;
  logic lock;
  logic window_mode;
  swt_pkg::swt_cfg_t cfg;
  swt_pkg::swt_phase_t phase;
  int fails;
  int checks;
  int cycles;
  int resets;
  int irqs;
  int r0;
  int i0;
  int len;

  swt_top #(.TICK_CYCLES(TICK)) DUT (
    .clk(clk),
    .rst(rst),
    .enable(enable),
    .windowed_operation_enable(wen),
    .permanent_run_lock_set(lock_set),
    .cfg_write(cfg_write),
    .cfg_data(cfg_data),
    .early_warning_irq_enable_set(ew_set),
    .early_warning_irq_enable_clear(ew_clr),
    .refresh(refresh),
    .system_reset(system_reset),
    .early_warning_irq(early_warning_irq),
    .early_warning_irq_enable(ew_en),
    .permanent_run_lock(lock),
    .window_mode(window_mode),
    .cfg(cfg),
    .phase(phase)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // pulse counters and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (system_reset === 1'b1) resets++;
    if (early_warning_irq === 1'b1) irqs++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // phase length may trail the tick count by a cycle or two of registering
  task automatic chk_len(input int got, input int exp);
    checks++;
    if (got < exp || got > exp + 2)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic write_cfg(input logic [7:0] d);
    @(negedge clk);
    cfg_write = 1'b1;
    cfg_data = d;
    @(negedge clk);
    cfg_write = 1'b0;
  endtask

  task automatic write_ew(input logic set);
    @(negedge clk);
    ew_set = set;
    ew_clr = !set;
    @(negedge clk);
    ew_set = 1'b0;
    ew_clr = 1'b0;
  endtask

  task automatic send_refresh(input logic [7:0] d);
    @(negedge clk);
    refresh.valid = 1'b1;
    refresh.data = d;
    @(negedge clk);
    refresh.valid = 1'b0;
  endtask

  task automatic wait_phase(input swt_pkg::swt_phase_t p);
    int n;
    n = 0;
    while (phase !== p && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(phase, p);
  endtask

  task automatic time_phase(input swt_pkg::swt_phase_t p, output int n);
    wait_phase(p);
    n = 0;
    while (phase === p && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  initial
  begin
    rst = 1'b1;
    {enable, wen, lock_set, cfg_write, ew_set, ew_clr} = '0;
    cfg_data = '0;
    refresh = '0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk(cfg, 16'h00bb);
    chk(ew_en, 16'h0000);
    chk(lock, 16'h0000);
    chk(phase, swt_pkg::SWT_PH_IDLE);
    $display("test reset_values done");
    write_cfg(8'h10);
    chk(cfg, 16'h0010);
    write_ew(1'b1);
    chk(ew_en, 16'h0001);
    wen = 1'b1;
    step(1);
    enable = 1'b1;
    r0 = resets;
    i0 = irqs;
    time_phase(swt_pkg::SWT_PH_CLOSED, len);
    chk_len(len, 16 * TICK);
    chk(irqs - i0, 16'h0000);
    time_phase(swt_pkg::SWT_PH_OPEN, len);
    chk_len(len, 8 * TICK);
    step(2);
    chk(irqs - i0, 16'h0001);
    chk(resets - r0, 16'h0001);
    $display("test timeout_span done");
    step(5);
    r0 = resets;
    send_refresh(8'ha5);
    step(2);
    chk(resets - r0, 16'h0001);
    $display("test early_refresh done");
    wait_phase(swt_pkg::SWT_PH_OPEN);
    step(3);
    r0 = resets;
    send_refresh(8'ha5);
    step(2);
    chk(resets - r0, 16'h0000);
    chk(phase, swt_pkg::SWT_PH_CLOSED);
    step(16 * TICK - 8);
    chk(phase, swt_pkg::SWT_PH_CLOSED);
    wait_phase(swt_pkg::SWT_PH_OPEN);
    r0 = resets;
    send_refresh(8'h5a);
    step(2);
    chk(resets - r0, 16'h0001);
    $display("test open_refresh done");
    write_ew(1'b0);
    chk(ew_en, 16'h0000);
    i0 = irqs;
    wait_phase(swt_pkg::SWT_PH_OPEN);
    step(3);
    chk(irqs - i0, 16'h0000);
    $display("test irq_disable done");
    @(negedge clk) lock_set = 1'b1;
    @(negedge clk) lock_set = 1'b0;
    chk(lock, 16'h0001);
    enable = 1'b0;
    step(4);
    chk(phase === swt_pkg::SWT_PH_IDLE, 16'h0000);
    write_cfg(8'h22);
    chk(cfg, 16'h0010);
    wen = 1'b0;
    step(2);
    chk(window_mode, 16'h0000);
    wen = 1'b1;
    step(2);
    chk(window_mode, 16'h0001);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(3);
    chk(lock, 16'h0000);
    chk(phase, swt_pkg::SWT_PH_IDLE);
    $display("test permanent_lock done");
    complete_run();
  end
endmodule // swt_top_bench
